//--- core/power_load_clear_consts.svh
// constants for the power-down, dac-load and software-clear command logic
// assumes 16-bit command words arrive already decoded by command byte
`ifndef POWER_LOAD_CLEAR_CONSTS_SVH
`define POWER_LOAD_CLEAR_CONSTS_SVH
`define CMD_DAC_LOAD 8'h66
`define CMD_SW_CLEAR 8'h74
`define CMD_POWER_DOWN 8'h4c
`define PD_GLOBAL_BIT 11
`define PD_CH2_SENSE_BIT 7
`define PD_CH2_GATE_BIT 6
`define PD_CH2_SUM_BIT 5
`define PD_CH2_DAC_BIT 4
`define PD_CH1_SENSE_BIT 3
`define PD_CH1_GATE_BIT 2
`define PD_CH1_SUM_BIT 1
`define PD_CH1_DAC_BIT 0
`define PD_RESET 9'h1ff
`define LD_CH2_BIT 1
`define LD_CH1_BIT 0
`define CLR_FULL_BIT 6
`define CLR_ARM_BIT 5
`define CLR_ALARM_BIT 4
`define CLR_CACHE_BIT 3
`define CLR_QUEUE_BIT 2
`define CLR_CH2_BIT 1
`define CLR_CH1_BIT 0
`define DAC_RESET 12'h000
`define INIT_CYCLES 16
`endif

//--- core/power_load_clear_control.sv
// command-register logic: power-down word, dac-load strobes, software-clear word
// assumes cmdValid is a one-cycle pulse on clk from the serial decoder
//
// Behaviour
// - bits 7..4 power down ch2 sense, gate amp, sum node, dac; reset to one.
// - bits 3..0 power down ch1 sense, gate amp, sum node, dac; reset to one.
// - dac-load bit 1 copies ch2 input to output; bits 15..2 ignored.
// - dac-load bit 0 copies ch1 input to output.
// - full reset only after the completing second write; arm resets to zero.
// - full reset restores all registers except global power-down, left clear; oscillator keeps running.
// - after full reset commands accepted without clearing global power-down.
// - busy high while ram initializes during full reset, then low.
// - clear bit 4 resets alarm thresholds and alarm flags.
// - clear bit 3 returns table pointers and lookup cache to power-up.
// - after cache clear next sample always forces lookup and code calculation.
// - clear bit 2 resets queue pointers and discards contents.
// - clear bit 1 resets ch2 dac input and output registers.
// - clear bit 0 resets ch1 dac input and output registers.
// - global power-down at bit 11 is one at power-up and overrides all.
`timescale 1ns/1ps
`include "power_load_clear_consts.svh"
module power_load_clear_control #(
	parameter int INIT_CYCLES = `INIT_CYCLES
)(
	input wire logic clk,
	input wire logic reset,
	input wire logic cmdValid,
	input wire logic [7:0] cmdByte,
	input wire power_load_clear_pkg::cmd_word_t cmdData,
	input wire logic ch1InWrite,
	input wire logic ch2InWrite,
	input wire power_load_clear_pkg::dac_code_t dacInData,
	input wire logic sampleDone,
	output logic globalPowerDown,
	output logic ch2SenseAmpOff,
	output logic ch2GateAmpOff,
	output logic ch2SumNodeOff,
	output logic ch2DacOff,
	output logic ch1SenseAmpOff,
	output logic ch1GateAmpOff,
	output logic ch1SumNodeOff,
	output logic ch1DacOff,
	output power_load_clear_pkg::dac_code_t ch1InReg,
	output power_load_clear_pkg::dac_code_t ch2InReg,
	output power_load_clear_pkg::dac_code_t ch1OutReg,
	output power_load_clear_pkg::dac_code_t ch2OutReg,
	output logic alarmClear,
	output logic cacheClear,
	output logic forceLookup,
	output logic queueClear,
	output logic ramInit,
	output logic busy,
	output logic cmdAccepted
);
	import power_load_clear_pkg::*;
	// the init counter is 16 bits wide
	if (INIT_CYCLES < 1 || INIT_CYCLES > 65535)
	begin : g_bad_init
		$error("INIT_CYCLES out of range");
	end

	typedef struct packed {
		logic [8:0] pd;
		logic arm;
		dac_code_t in1;
		dac_code_t in2;
		dac_code_t out1;
		dac_code_t out2;
		logic almClr;
		logic lookup_cache_clear_bit;
		logic force_;
		logic queueClr;
		init_state_e st;
		logic [15:0] cnt;
	} state_s;

	state_s s_r;
	state_s s_nxt;
	logic isPd;
	logic isLoad;
	logic isClear;
	logic fullGo;

	////////////////////////////////////////////////////////////////////////
	assign isPd = cmdValid && cmdByte == `CMD_POWER_DOWN;
	assign isLoad = cmdValid && cmdByte == `CMD_DAC_LOAD;
	assign isClear = cmdValid && cmdByte == `CMD_SW_CLEAR;
	// second write completes the armed sequence
	assign fullGo = isClear && s_r.arm && cmdData[`CLR_FULL_BIT] && !cmdData[`CLR_ARM_BIT];

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.almClr = 1'b0;
		s_nxt.lookup_cache_clear_bit = 1'b0;
		s_nxt.queueClr = 1'b0;
		if (sampleDone)
			s_nxt.force_ = 1'b0;
		if (ch1InWrite)
			s_nxt.in1 = dacInData;
		if (ch2InWrite)
			s_nxt.in2 = dacInData;
		if (s_r.st == INIT)
		begin
			if (s_r.cnt == 16'(INIT_CYCLES - 1))
				s_nxt.st = IDLE;
			else
				s_nxt.cnt = s_r.cnt + 16'h0001;
		end
		if (isPd)
			s_nxt.pd = {cmdData[`PD_GLOBAL_BIT], cmdData[7:0]};
		if (isLoad)
		begin
			if (cmdData[`LD_CH2_BIT])
				s_nxt.out2 = s_r.in2;
			if (cmdData[`LD_CH1_BIT])
				s_nxt.out1 = s_r.in1;
		end
		if (isClear)
		begin
			s_nxt.arm = cmdData[`CLR_ARM_BIT] && !cmdData[`CLR_FULL_BIT];
			if (cmdData[`CLR_ALARM_BIT])
				s_nxt.almClr = 1'b1;
			if (cmdData[`CLR_CACHE_BIT])
			begin
				s_nxt.lookup_cache_clear_bit = 1'b1;
				s_nxt.force_ = 1'b1;
			end
			if (cmdData[`CLR_QUEUE_BIT])
				s_nxt.queueClr = 1'b1;
			if (cmdData[`CLR_CH2_BIT])
			begin
				s_nxt.in2 = `DAC_RESET;
				s_nxt.out2 = `DAC_RESET;
			end
			if (cmdData[`CLR_CH1_BIT])
			begin
				s_nxt.in1 = `DAC_RESET;
				s_nxt.out1 = `DAC_RESET;
			end
		end
		if (fullGo)
		begin
			// power-off values, but global power-down left clear
			s_nxt.pd = `PD_RESET;
			s_nxt.pd[`PD_GLOBAL_BIT - 3] = 1'b0;
			s_nxt.arm = 1'b0;
			s_nxt.in1 = `DAC_RESET;
			s_nxt.in2 = `DAC_RESET;
			s_nxt.out1 = `DAC_RESET;
			s_nxt.out2 = `DAC_RESET;
			s_nxt.almClr = 1'b1;
			s_nxt.lookup_cache_clear_bit = 1'b1;
			s_nxt.force_ = 1'b1;
			s_nxt.queueClr = 1'b1;
			s_nxt.st = INIT;
			s_nxt.cnt = 16'h0000;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			s_r <= '0;
			s_r.pd <= `PD_RESET;
			s_r.st <= IDLE;
		end
		else
			s_r <= s_nxt;
	end

	////////////////////////////////////////////////////////////////////////
	// register bits 8..0 map data bits 11,7..0 (bits 10..8 live elsewhere)
	assign globalPowerDown = s_r.pd[8];
	assign ch2SenseAmpOff = s_r.pd[8] | s_r.pd[`PD_CH2_SENSE_BIT];
	assign ch2GateAmpOff = s_r.pd[8] | s_r.pd[`PD_CH2_GATE_BIT];
	assign ch2SumNodeOff = s_r.pd[8] | s_r.pd[`PD_CH2_SUM_BIT];
	assign ch2DacOff = s_r.pd[8] | s_r.pd[`PD_CH2_DAC_BIT];
	assign ch1SenseAmpOff = s_r.pd[8] | s_r.pd[`PD_CH1_SENSE_BIT];
	assign ch1GateAmpOff = s_r.pd[8] | s_r.pd[`PD_CH1_GATE_BIT];
	assign ch1SumNodeOff = s_r.pd[8] | s_r.pd[`PD_CH1_SUM_BIT];
	assign ch1DacOff = s_r.pd[8] | s_r.pd[`PD_CH1_DAC_BIT];
	assign ch1InReg = s_r.in1;
	assign ch2InReg = s_r.in2;
	assign ch1OutReg = s_r.out1;
	assign ch2OutReg = s_r.out2;
	assign alarmClear = s_r.almClr;
	assign cacheClear = s_r.lookup_cache_clear_bit;
	assign forceLookup = s_r.force_;
	assign queueClear = s_r.queueClr;
	assign ramInit = s_r.st == INIT;
	assign busy = s_r.st == INIT;
	assign cmdAccepted = isPd | isLoad | isClear;

	////////////////////////////////////////////////////////////////////////
	sequence armWrite;
		isClear && !cmdData[`CLR_FULL_BIT] && cmdData[`CLR_ARM_BIT];
	endsequence
	sequence fireWrite;
		isClear && cmdData[`CLR_FULL_BIT] && !cmdData[`CLR_ARM_BIT];
	endsequence

	full_reset_busy_a: assert property (@(posedge clk) disable iff (reset)
		armWrite ##1 (!isClear)[*3] ##1 fireWrite |=> busy)
		else $error("full reset did not start");
	busy_ends_a: assert property (@(posedge clk) disable iff (reset)
		$fell(busy) |-> $past(busy, INIT_CYCLES) && !$past(busy, INIT_CYCLES + 1))
		else $error("busy length wrong");
	no_fire_unarmed_a: assert property (@(posedge clk) disable iff (reset)
		$rose(busy) |-> $past(s_r.arm))
		else $error("full reset without arm");
	after_full_a: assert property (@(posedge clk) disable iff (reset)
		$rose(busy) |-> !globalPowerDown && ch1DacOff && ch2GateAmpOff && ch1OutReg == 12'h000)
		else $error("full reset state wrong");
	load_ch2_a: assert property (@(posedge clk) disable iff (reset)
		isLoad && cmdData[1] && !fullGo |=> ch2OutReg == $past(ch2InReg))
		else $error("ch2 load failed");
	load_ch1_a: assert property (@(posedge clk) disable iff (reset)
		isLoad && cmdData[0] && !fullGo |=> ch1OutReg == $past(ch1InReg))
		else $error("ch1 load failed");
	clear_ch2_a: assert property (@(posedge clk) disable iff (reset)
		isClear && cmdData[1] && !ch2InWrite |=> ch2InReg == 12'h000 && ch2OutReg == 12'h000)
		else $error("ch2 clear failed");
	clear_ch1_a: assert property (@(posedge clk) disable iff (reset)
		isClear && cmdData[0] && !ch1InWrite |=> ch1InReg == 12'h000 && ch1OutReg == 12'h000)
		else $error("ch1 clear failed");
	strobe_pulse_a: assert property (@(posedge clk) disable iff (reset)
		queueClear |=> !queueClear || $past(isClear))
		else $error("queue clear held");
	alarm_strobe_a: assert property (@(posedge clk) disable iff (reset)
		isClear && cmdData[4] |=> alarmClear)
		else $error("alarm clear missing");
	cache_force_a: assert property (@(posedge clk) disable iff (reset)
		isClear && cmdData[3] |=> cacheClear && forceLookup)
		else $error("cache clear missing");
	queue_strobe_a: assert property (@(posedge clk) disable iff (reset)
		isClear && cmdData[2] |=> queueClear)
		else $error("queue clear missing");
	pd_override_a: assert property (@(posedge clk) disable iff (reset)
		globalPowerDown |-> ch1SenseAmpOff && ch2DacOff && ch1GateAmpOff)
		else $error("global power-down not dominant");
endmodule : power_load_clear_control

//--- core/power_load_clear_pkg.sv
// types for the power-down, dac-load and software-clear command logic
// assumes the constants header is compiled alongside
package power_load_clear_pkg;
	typedef enum logic [1:0] {
		IDLE = 2'b00,
		INIT = 2'b01
	} init_state_e;
	typedef logic [11:0] dac_code_t;
	typedef logic [15:0] cmd_word_t;
endpackage : power_load_clear_pkg

//--- tb/power_load_clear_control_tb_top.sv
// testbench for the power-down, dac-load and software-clear command logic
// assumes the design package is compiled first; the bench drives every input itself
`timescale 1ns/1ps
module power_load_clear_control_tb_top;
	import power_load_clear_pkg::*;
	localparam int INIT = 4;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic cmdValid = 1'b0;
	logic ch1InWrite = 1'b0;
	logic ch2InWrite = 1'b0;
	logic sampleDone = 1'b0;
	logic [7:0] cmdByte = 8'h00;
	cmd_word_t cmdData = 16'h0000;
	dac_code_t dacInData = 12'h000;
	dac_code_t ch1InReg, ch2InReg, ch1OutReg, ch2OutReg;
	logic globalPowerDown, busy, ramInit, alarmClear, cacheClear, forceLookup, queueClear, cmdAccepted;
	wire [7:0] pd;
	int n_fail = 0;
	int cmp_count = 0;
	always #25 clk = ~clk;
	power_load_clear_control #(.INIT_CYCLES(INIT)) power_load_clear_control_inst (.clk(clk), .reset(reset),
		.cmdValid(cmdValid), .cmdByte(cmdByte), .cmdData(cmdData), .ch1InWrite(ch1InWrite), .ch2InWrite(ch2InWrite),
		.dacInData(dacInData), .sampleDone(sampleDone), .globalPowerDown(globalPowerDown),
		.ch2SenseAmpOff(pd[7]), .ch2GateAmpOff(pd[6]), .ch2SumNodeOff(pd[5]), .ch2DacOff(pd[4]),
		.ch1SenseAmpOff(pd[3]), .ch1GateAmpOff(pd[2]), .ch1SumNodeOff(pd[1]), .ch1DacOff(pd[0]),
		.ch1InReg(ch1InReg), .ch2InReg(ch2InReg), .ch1OutReg(ch1OutReg), .ch2OutReg(ch2OutReg),
		.alarmClear(alarmClear), .cacheClear(cacheClear), .forceLookup(forceLookup), .queueClear(queueClear),
		.ramInit(ramInit), .busy(busy), .cmdAccepted(cmdAccepted));
////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk
	task automatic tally_and_finish;
		if (n_fail == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish
	task automatic tick;
		@(posedge clk);
		#1;
	endtask : tick
	// one command word; returns just after the taking edge has updated the registers
	task automatic cmd(input logic [7:0] b, input logic [15:0] d);
		@(posedge clk);
		cmdValid <= 1'b1;
		cmdByte <= b;
		cmdData <= d;
		#1;
		chk("command accepted", {15'h0000, b == 8'h66 || b == 8'h74 || b == 8'h4c}, cmdAccepted);
		@(posedge clk);
		cmdValid <= 1'b0;
		#1;
	endtask : cmd
	task automatic wr_in(input logic [1:0] ch, input logic [11:0] v);
		@(posedge clk);
		{ch2InWrite, ch1InWrite} <= ch;
		dacInData <= v;
		@(posedge clk);
		{ch2InWrite, ch1InWrite} <= 2'b00;
		#1;
	endtask : wr_in
////////////////////////////////////////////////////////////////////////////////
	task automatic t_power;
		logic [15:0] pat [4] = '{16'hf755, 16'h00aa, 16'h0800, 16'h0000};
		chk("reset pd", 16'h01ff, {globalPowerDown, pd});
		chk("reset dac", 16'h0000, ch1OutReg | ch2OutReg | ch1InReg | ch2InReg);
		foreach (pat[i])
		begin
			cmd(8'h4c, pat[i]);
			chk("pd outputs", {8'h00, pat[i][7:0] | {8{pat[i][11]}}}, pd);
		end
		cmd(8'h11, 16'hffff);
		chk("pd unknown byte", 16'h0000, pd);
	endtask : t_power
	task automatic t_load;
		wr_in(2'b01, 12'h5a3);
		wr_in(2'b10, 12'h3c6);
		chk("ch1 out early", 16'h0000, ch1OutReg);
		cmd(8'h66, 16'hfffe);
		chk("ch2 out", 16'h03c6, ch2OutReg);
		chk("ch1 out kept", 16'h0000, ch1OutReg);
		cmd(8'h66, 16'h0001);
		chk("ch1 out", 16'h05a3, ch1OutReg);
	endtask : t_load
	task automatic t_clear;
		cmd(8'h74, 16'hff90);
		chk("alarm clear", 16'h0004, {alarmClear, cacheClear, queueClear});
		tick();
		chk("alarm pulse", 16'h0000, alarmClear);
		cmd(8'h74, 16'h0008);
		chk("cache clear", 16'h0003, {cacheClear, forceLookup});
		tick();
		chk("lookup held", 16'h0001, {cacheClear, forceLookup});
		@(posedge clk);
		sampleDone <= 1'b1;
		@(posedge clk);
		sampleDone <= 1'b0;
		#1;
		chk("lookup done", 16'h0000, forceLookup);
		cmd(8'h74, 16'h0004);
		chk("queue clear", 16'h0001, queueClear);
		tick();
		chk("queue pulse", 16'h0000, queueClear);
		cmd(8'h74, 16'h0002);
		chk("ch2 cleared", 16'h0000, ch2InReg | ch2OutReg);
		chk("ch1 kept", 16'h05a3, ch1OutReg);
		cmd(8'h74, 16'h0001);
		chk("ch1 cleared", 16'h0000, ch1InReg | ch1OutReg);
	endtask : t_clear
	task automatic t_full;
		int n;
		cmd(8'h74, 16'h0040);
		chk("busy unarmed", 16'h0000, busy);
		cmd(8'h74, 16'h0020);
		cmd(8'h74, 16'h0000);
		cmd(8'h74, 16'h0040);
		chk("busy disarmed", 16'h0000, busy);
		wr_in(2'b11, 12'h7e1);
		cmd(8'h74, 16'h0020);
		cmd(8'h66, 16'h0000);
		cmd(8'h74, 16'h0040);
		chk("busy start", 16'h0003, {busy, ramInit});
		chk("pd full reset", 16'h00ff, {globalPowerDown, pd});
		chk("dac full reset", 16'h0000, ch1InReg | ch2InReg | ch1OutReg | ch2OutReg);
		chk("strobes full reset", 16'h0007, {alarmClear, cacheClear, queueClear});
		n = 0;
		while (busy === 1'b1 && n < 100)
		begin
			tick();
			n++;
		end
		chk("busy cycles", 16'(INIT), 16'(n));
		if (n == 100)
			tally_and_finish();
		wr_in(2'b01, 12'h2b4);
		cmd(8'h66, 16'h0001);
		chk("load after reset", 16'h02b4, ch1OutReg);
	endtask : t_full
	task automatic t_reset;
		cmd(8'h4c, 16'h0000);
		@(posedge clk);
		reset <= 1'b1;
		@(posedge clk);
		reset <= 1'b0;
		#1;
		chk("pd after reset", 16'h01ff, {globalPowerDown, pd});
		chk("dac after reset", 16'h0000, ch1OutReg);
		cmd(8'h4c, 16'h0000);
		chk("pd cleared again", 16'h0000, {globalPowerDown, pd});
	endtask : t_reset
////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		t_power();
		t_load();
		t_clear();
		t_full();
		t_reset();
		tally_and_finish();
	end
endmodule : power_load_clear_control_tb_top
